// >>> fmds_pkg.sv
// Constants, encodings and state type for the float multiply, divide and square root unit.
// Assumes short operands of 8-bit exponent and 24-bit coefficient, long of 16 and 48.
package fmds_pkg;

  // ----------------------------------------------------------------
  // Operation codes and controller states
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_MUL = 2'h0;
  localparam logic [1:0] OP_DIV = 2'h1;
  localparam logic [1:0] OP_SQRT = 2'h2;

  typedef enum logic [1:0] {FMDS_IDLE, FMDS_DIV, FMDS_ADJ, FMDS_FIN} fmds_state_t;

  // ----------------------------------------------------------------
  // Special result codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SP_NONE = 2'h0;
  localparam logic [1:0] SP_INDEF = 2'h1;
  localparam logic [1:0] SP_ZERO = 2'h2;

  // ----------------------------------------------------------------
  // Operand format tags, ranges and coefficient patterns
  // ----------------------------------------------------------------
  localparam logic [3:0] INDEF_TAG = 4'h7;
  localparam logic [3:0] ZERO_TAG = 4'h8;
  localparam logic [17:0] S_EMAX = 18'h0_006f;
  localparam logic [17:0] S_EMIN = 18'h3_ff90;
  localparam logic [17:0] L_EMAX = 18'h0_6fff;
  localparam logic [17:0] L_EMIN = 18'h3_9000;
  localparam logic [15:0] S_INDEF_EXP = 16'h0070;
  localparam logic [15:0] S_ZERO_EXP = 16'h0080;
  localparam logic [15:0] L_INDEF_EXP = 16'h7000;
  localparam logic [15:0] L_ZERO_EXP = 16'h8000;
  localparam logic [47:0] S_MOSTNEG = 48'hffff_ff80_0000;
  localparam logic [47:0] L_MOSTNEG = 48'h8000_0000_0000;
  localparam logic [47:0] S_HALF = 48'h0000_0040_0000;
  localparam logic [47:0] L_HALF = 48'h4000_0000_0000;

  // ----------------------------------------------------------------
  // Exponent offsets and sequence counts
  // ----------------------------------------------------------------
  localparam logic [17:0] UP_OFS = 18'h0_0017;
  localparam logic [17:0] DIV_BIAS = 18'h0_0016;
  localparam logic [17:0] SQ_SOFS = 18'h0_000b;
  localparam logic [17:0] SQ_LOFS = 18'h0_0017;
  localparam logic [4:0] DIV_LAST = 5'h16;
  localparam logic [5:0] SHORT_MAG = 6'h17;

  // ----------------------------------------------------------------
  // Modifier bit positions
  // ----------------------------------------------------------------
  localparam int MOD_WIDE = 0;
  localparam int MOD_CTRL = 1;
  localparam int MOD_OFS = 2;
  localparam int MOD_BC_LO = 3;
  localparam int MOD_BC_HI = 4;
  localparam int MOD_SC_LO = 5;
  localparam int MOD_SC_HI = 7;

endpackage : fmds_pkg

// >>> fmds_unit.sv
// Float multiply, divide and square root datapath with significance adjustment.
// Assumes the pipeline holds operands and START steady only in the cycle it pulses START.
//
// How it works
// - Multiply puts low 23 product bits in lower result, next 23 in upper.
// - Lower multiply result always has its sign bit cleared.
// - Multiply works on magnitudes; signs set upper sign and product complement.
// - Most negative coefficient is halved with exponent bumped before complementing.
// - Lower exponent is the exponent sum; upper adds hex 17.
// - Short exponent above hex 6F gives indefinite, below hex 90 gives machine zero; long limits are hex 6FFF and 9000.
// - Indefinite operand or machine zero divisor gives indefinite, else machine zero operand gives machine zero.
// - Divide uses magnitudes and a prenormalized divisor, 23-bit quotient upper.
// - Divisor shifts left until top one sits beside sign; count kept.
// - Restoring division, 23 subtractions and 23 shifts.
// - Quotient complemented if signs differ; no rounding, remainder dropped.
// - Significance is magnitude bits minus normalize shift; all zeros or ones is zero.
// - Input significance is measured on raw fetched operands.
// - Significant mode shifts result to the smaller input significance.
// - Significant multiply shifts the whole double-length product.
// - Range checks follow the significance adjustment.
// - Square root complements negatives; odd exponent is decremented, coefficient doubled.
// - Zeros are appended so root gives 23 or 47 bits.
// - Root exponent is halved minus 11 or 23; root complemented if input negative.
// - Root is rescaled to input significance with exponent compensated.
// - Zero coefficient root halves exponent; negative input raises flag 45.
// - Modifier bits decode to width, control, offset, broadcast, sign or index.
// - Exponent underflow from a decrement forces machine zero.
`timescale 1ns/100ps

module fmds_unit
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic START,
  input wire logic [1:0] OP,
  input wire logic SIGNIF,
  input wire logic [7:0] MOD,
  input wire logic [63:0] A,
  input wire logic [63:0] B,
  output logic BUSY,
  output logic DONE,
  output logic [63:0] UPPER,
  output logic [63:0] LOWER,
  output logic FLAG45,
  output logic WIDE,
  output logic CTRL_VEC,
  output logic OFFSET_SEL,
  output logic [1:0] BCAST,
  output logic [2:0] SIGN_IDX
);
  import fmds_pkg::*;

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    fmds_state_t st;
    logic [1:0] op;
    logic sgn;
    logic lng;
    logic neg;
    logic [1:0] spec;
    logic [5:0] sig_in;
    logic [47:0] wk;
    logic [17:0] ex;
    logic [24:0] rem;
    logic [23:0] dvs;
    logic [22:0] q;
    logic [4:0] cnt;
    logic [7:0] mod;
    logic [63:0] up;
    logic [63:0] lo;
    logic f45;
  } fmds_regs_t;

  fmds_regs_t r_q;
  fmds_regs_t r_d;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Operand exponent, sign extended to the working width.
  function automatic logic [17:0] exp_of(input logic [63:0] v, input logic lng);
    return lng ? {{2{v[63]}}, v[63:48]} : {{10{v[31]}}, v[31:24]};
  endfunction : exp_of

  // Operand coefficient, sign extended to 48 bits.
  function automatic logic [47:0] coef_of(input logic [63:0] v, input logic lng);
    return lng ? v[47:0] : {{24{v[23]}}, v[23:0]};
  endfunction : coef_of

  // Top exponent nibble, which tags indefinite and machine zero.
  function automatic logic [3:0] tag_of(input logic [63:0] v, input logic lng);
    return lng ? v[63:60] : v[31:28];
  endfunction : tag_of

  // Significant bit count of a short or long coefficient.
  function automatic logic [5:0] sig_cnt(input logic [47:0] c, input logic lng);
    logic [5:0] s;
    logic sb;
    s = '0;
    sb = lng ? c[47] : c[23];
    for (int i = 0; i < 47; i++)
    begin
      if ((lng || i < 23) && c[i] != sb)
        s = 6'(i + 1);
    end
    return s;
  endfunction : sig_cnt

  // Magnitude of a coefficient, with the exponent bump flag on top.
  function automatic logic [48:0] abs_fix(input logic [47:0] c, input logic lng);
    if (c == (lng ? L_MOSTNEG : S_MOSTNEG))
      return {1'b1, lng ? L_HALF : S_HALF};
    return {1'b0, c[47] ? 48'(-c) : c};
  endfunction : abs_fix

  // Restoring integer square root, two radicand bits per step.
  function automatic logic [46:0] isqrt(input logic [93:0] x);
    logic [46:0] r;
    logic [48:0] rm;
    logic [48:0] t;
    r = '0;
    rm = '0;
    t = '0;
    for (int i = 46; i >= 0; i--)
    begin
      rm = {rm[46:0], x[2*i+1 -: 2]};
      t = {r, 2'b01};
      if (rm >= t)
      begin
        rm = rm - t;
        r = {r[45:0], 1'b1};
      end
      else
        r = {r[45:0], 1'b0};
    end
    return r;
  endfunction : isqrt

  // Exponent range check; an earlier special code wins.
  function automatic logic [1:0] range_chk(input logic [17:0] e, input logic lng,
                                           input logic [1:0] sp);
    if (sp != SP_NONE)
      return sp;
    if ($signed(e) > $signed(lng ? L_EMAX : S_EMAX))
      return SP_INDEF;
    if ($signed(e) < $signed(lng ? L_EMIN : S_EMIN))
      return SP_ZERO;
    return SP_NONE;
  endfunction : range_chk

  // Result word in the selected width, with forced results substituted.
  function automatic logic [63:0] pack(input logic [1:0] sp, input logic [17:0] e,
                                       input logic [47:0] c, input logic lng);
    logic [15:0] pe;
    logic [47:0] pc;
    pe = e[15:0];
    pc = c;
    if (sp == SP_INDEF)
    begin
      pe = lng ? L_INDEF_EXP : S_INDEF_EXP;
      pc = '0;
    end
    else if (sp == SP_ZERO)
    begin
      pe = lng ? L_ZERO_EXP : S_ZERO_EXP;
      pc = '0;
    end
    return lng ? {pe, pc} : {32'h0000_0000, pe[7:0], pc[23:0]};
  endfunction : pack

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic lng_in;
  logic [17:0] ea;
  logic [17:0] eb;
  logic [47:0] ca;
  logic [47:0] cb;
  logic [48:0] fa;
  logic [48:0] fb;
  logic ia;
  logic ib;
  logic za;
  logic zb;
  logic [5:0] siga;
  logic [5:0] sigb;

  // Operand decode for the request presented with START.
  assign lng_in = MOD[MOD_WIDE] && OP[1];
  assign ea = exp_of(A, lng_in);
  assign eb = exp_of(B, lng_in);
  assign ca = coef_of(A, lng_in);
  assign cb = coef_of(B, lng_in);
  assign fa = abs_fix(ca, lng_in);
  assign fb = abs_fix(cb, lng_in);
  assign ia = tag_of(A, lng_in) == INDEF_TAG;
  assign ib = tag_of(B, lng_in) == INDEF_TAG;
  assign za = tag_of(A, lng_in) == ZERO_TAG;
  assign zb = tag_of(B, lng_in) == ZERO_TAG;
  assign siga = sig_cnt(ca, lng_in);
  assign sigb = sig_cnt(cb, lng_in);

  // Sequencer and datapath for all three operations.
  always_comb
  begin
    logic [45:0] prod;
    logic [5:0] nc;
    logic [5:0] rs;
    logic [5:0] d;
    logic [17:0] e;
    logic [47:0] m;
    logic [93:0] rad;
    logic [46:0] root;
    logic [24:0] rn;
    prod = '0;
    nc = '0;
    rs = '0;
    d = '0;
    e = '0;
    m = '0;
    rad = '0;
    root = '0;
    rn = '0;
    r_d = r_q;
    case (r_q.st)
      FMDS_IDLE:
      begin
        if (START)
        begin
          r_d.mod = MOD;
          r_d.op = OP;
          r_d.sgn = SIGNIF;
          r_d.lng = lng_in;
          r_d.f45 = 1'b0;
          r_d.sig_in = (siga < sigb) ? siga : sigb;
          r_d.neg = ca[47] ^ cb[47];
          r_d.st = FMDS_ADJ;
          case (OP)
            OP_MUL:
            begin
              prod = fa[22:0] * fb[22:0];
              r_d.wk = r_d.neg ? 48'(-{2'b00, prod}) : {2'b00, prod};
              r_d.ex = ea + eb + 18'(fa[48]) + 18'(fb[48]) + UP_OFS;
              r_d.spec = (ia || ib) ? SP_INDEF : (za || zb) ? SP_ZERO : SP_NONE;
            end
            OP_DIV:
            begin
              nc = SHORT_MAG - sig_cnt(fb[47:0], 1'b0);
              r_d.dvs = fb[23:0] << nc;
              r_d.rem = {1'b0, fa[23:0]};
              r_d.q = '0;
              r_d.cnt = '0;
              r_d.ex = ea + 18'(fa[48]) - eb - 18'(fb[48]) + 18'(nc) - DIV_BIAS;
              r_d.spec = (ia || ib || zb || fb[47:0] == '0) ? SP_INDEF :
                         za ? SP_ZERO : SP_NONE;
              r_d.st = FMDS_DIV;
            end
            default:
            begin
              r_d.sig_in = siga;
              r_d.neg = ca[47];
              e = ea + 18'(fa[48]);
              m = fa[47:0];
              if (e[0])
              begin
                e = e - 18'h0_0001;
                m = m << 1;
              end
              rad = lng_in ? {m, 46'h0000_0000_0000} : {48'h0000_0000_0000, m[23:0], 22'h00_0000};
              root = isqrt(rad);
              r_d.wk = ca[47] ? 48'(-{1'b0, root}) : {1'b0, root};
              r_d.ex = 18'($signed(e) >>> 1) - (lng_in ? SQ_LOFS : SQ_SOFS);
              if (ca == '0)
              begin
                r_d.wk = '0;
                r_d.ex = 18'($signed(ea) >>> 1);
              end
              r_d.spec = ia ? SP_INDEF : za ? SP_ZERO : SP_NONE;
              r_d.f45 = ca[47] && !ia && !za;
            end
          endcase
        end
      end
      FMDS_DIV:
      begin
        rn = r_q.rem;
        if (r_q.rem >= {1'b0, r_q.dvs})
        begin
          rn = r_q.rem - {1'b0, r_q.dvs};
          r_d.q = {r_q.q[21:0], 1'b1};
        end
        else
          r_d.q = {r_q.q[21:0], 1'b0};
        r_d.rem = rn << 1;
        r_d.cnt = r_q.cnt + 5'h01;
        if (r_q.cnt == DIV_LAST)
        begin
          r_d.wk = r_q.neg ? 48'(-{25'h000_0000, r_d.q}) : {25'h000_0000, r_d.q};
          r_d.st = FMDS_ADJ;
        end
      end
      FMDS_ADJ:
      begin
        if (r_q.spec == SP_NONE && (r_q.sgn || r_q.op[1]))
        begin
          rs = (r_q.op == OP_MUL) ? sig_cnt({24'h00_0000, r_q.wk[46:23]}, 1'b0) :
               sig_cnt(r_q.wk, r_q.lng);
          if (rs < r_q.sig_in)
          begin
            d = r_q.sig_in - rs;
            r_d.wk = r_q.wk << d;
            r_d.ex = r_q.ex - 18'(d);
          end
          else if (rs > r_q.sig_in)
          begin
            d = rs - r_q.sig_in;
            r_d.wk = 48'($signed(r_q.wk) >>> d);
            r_d.ex = r_q.ex + 18'(d);
          end
        end
        if (r_q.op == OP_MUL)
        begin
          r_d.up = pack(range_chk(r_d.ex, 1'b0, r_q.spec), r_d.ex,
                        {24'h00_0000, r_d.wk[46:23]}, 1'b0);
          r_d.lo = pack(range_chk(r_d.ex - UP_OFS, 1'b0, r_q.spec), r_d.ex - UP_OFS,
                        {25'h000_0000, r_d.wk[22:0]}, 1'b0);
        end
        else
        begin
          r_d.up = pack(range_chk(r_d.ex, r_q.lng, r_q.spec), r_d.ex, r_d.wk, r_q.lng);
          r_d.lo = '0;
        end
        r_d.st = FMDS_FIN;
      end
      FMDS_FIN:
      begin
        r_d.st = FMDS_IDLE;
      end
      default:
      begin
        r_d.st = FMDS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Whole record clears on reset, which leaves the sequencer idle.
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Handshake from state, data and decoded modifier fields from flops.
  assign BUSY = r_q.st != FMDS_IDLE;
  assign DONE = r_q.st == FMDS_FIN;
  assign UPPER = r_q.up;
  assign LOWER = r_q.lo;
  assign FLAG45 = r_q.f45;
  assign WIDE = r_q.mod[MOD_WIDE];
  assign CTRL_VEC = r_q.mod[MOD_CTRL];
  assign OFFSET_SEL = r_q.mod[MOD_OFS];
  assign BCAST = r_q.mod[MOD_BC_HI:MOD_BC_LO];
  assign SIGN_IDX = r_q.mod[MOD_SC_HI:MOD_SC_LO];

endmodule : fmds_unit

// >>> fmds_unit_properties.sv
// Port assertions for the float multiply, divide and square root unit.
// Assumes it is bound into fmds_unit and sees only that module's ports.
`timescale 1ns/100ps

module fmds_unit_chk
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic START,
  input wire logic [1:0] OP,
  input wire logic [7:0] MOD,
  input wire logic [63:0] A,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic [63:0] UPPER,
  input wire logic [63:0] LOWER,
  input wire logic FLAG45,
  input wire logic WIDE,
  input wire logic CTRL_VEC,
  input wire logic OFFSET_SEL,
  input wire logic [1:0] BCAST,
  input wire logic [2:0] SIGN_IDX
);
  import fmds_pkg::*;
  // ------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------
  logic take;
  logic [7:0] dec;
  logic [3:0] tag;
  // A request counts only while the unit is idle.
  assign take = START && !BUSY;
  assign dec = {SIGN_IDX, BCAST, OFFSET_SEL, CTRL_VEC, WIDE};
  assign tag = A[31:28];
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_mul_latency: assert property (take && OP != OP_DIV |=> BUSY ##1 DONE ##1 !BUSY)
    else $error("short operation result late or early");
  a_div_steps: assert property (take && OP == OP_DIV |=> !DONE[*8] ##17 DONE)
    else $error("divide result late or early");
  a_done_pulse: assert property (DONE |=> !DONE)
    else $error("done held over one cycle");
  a_mod_decode: assert property (take |=> dec == $past(MOD))
    else $error("modifier bits decoded wrongly");
  a_mod_hold: assert property (!take |=> $stable(dec))
    else $error("decoded modifiers changed without a request");
  a_lower_sign: assert property (DONE |-> !LOWER[23] && LOWER[63:32] == 32'h0)
    else $error("lower result sign set");
  a_result_load: assert property ($changed(UPPER) || $changed(LOWER) |-> DONE)
    else $error("result changed outside done");
  a_mul_indef: assert property (take && OP == OP_MUL && tag == INDEF_TAG |-> ##2
    UPPER[31:0] == {S_INDEF_EXP[7:0], 24'h00_0000})
    else $error("indefinite operand not passed on");
  a_flag_ops: assert property (take && !OP[1] |=> !FLAG45)
    else $error("flag set by multiply or divide");
  a_sqrt_neg: assert property (take && OP[1] && !MOD[MOD_WIDE] && A[23] &&
    tag != INDEF_TAG && tag != ZERO_TAG |-> ##2 FLAG45)
    else $error("negative root input did not raise flag");
  c_divide: cover property (take && OP == OP_DIV);
  c_refused: cover property (START && BUSY);
  c_flag: cover property (DONE && FLAG45);
endmodule : fmds_unit_chk

bind fmds_unit fmds_unit_chk u_chk
(
  .CLK(CLK), .RSTN(RSTN), .START(START), .OP(OP), .MOD(MOD), .A(A), .BUSY(BUSY),
  .DONE(DONE), .UPPER(UPPER), .LOWER(LOWER), .FLAG45(FLAG45), .WIDE(WIDE),
  .CTRL_VEC(CTRL_VEC), .OFFSET_SEL(OFFSET_SEL), .BCAST(BCAST), .SIGN_IDX(SIGN_IDX)
);

// >>> fmds_pipe_model.sv
// Pipeline model that hands one operation at a time to the unit.
// Assumes a free running clock; lines change only at its falling edge.
`timescale 1ns/100ps

module fmds_pipe_model
(
  input wire logic clk,
  input wire logic busy,
  input wire logic done,
  output logic start,
  output logic [1:0] op,
  output logic signif,
  output logic [7:0] mod_bits,
  output logic [63:0] a,
  output logic [63:0] b
);
  int waits;
  // ------------------------------------------------------------
  // Request driving
  // ------------------------------------------------------------
  // Lines are quiet at time zero.
  initial
  begin
    {start, op, signif, mod_bits, a, b} = '0;
  end

  // Pulses one request, then inverts the operand lines so no stale value is held.
  // A set poke raises a second request while busy, which the unit must ignore.
  task automatic issue(input logic [1:0] o, input logic s, input logic [7:0] m,
                       input logic [63:0] x, input logic [63:0] y, input logic poke);
    @(negedge clk);
    while (busy === 1'b1)
      @(negedge clk);
    {start, op, signif, mod_bits, a, b} = {1'b1, o, s, m, x, y};
    @(negedge clk);
    {start, op, signif, mod_bits, a, b} = {1'b0, ~o, ~s, ~m, ~x, ~y};
    waits = 0;
    while (done !== 1'b1 && waits < 40)
    begin
      @(negedge clk);
      waits++;
      start = poke && waits == 2;
    end
  endtask : issue
endmodule : fmds_pipe_model

// >>> fmds_tb.sv
// Self-checking bench for the float multiply, divide and square root unit.
// Assumes the package, the unit, its checker and the pipeline model come first.
`timescale 1ns/100ps

module tb;
  import fmds_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic start, signif, busy, done, flag45, wide, ctrl_vec, offset_sel;
  logic [1:0] op, bcast;
  logic [2:0] sign_idx;
  logic [7:0] mod_bits;
  logic [63:0] a, b, upper, lower;
  logic [31:0] x, y;
  int seed = 32'h0000_78e1;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int k;
  logic [63:0] mul_tab [8] = '{64'h0040_0000_0040_0000, 64'h1080_0000_0040_0000,
    64'h3040_0000_3040_0000, 64'h2c40_0000_2c40_0000, 64'hc840_0000_c840_0000,
    64'hc740_0000_c840_0000, 64'h7000_0000_8000_0000, 64'h8000_0000_0140_0000};
  logic [63:0] div_tab [7] = '{64'h0020_0000_0040_0000, 64'h0020_0000_0000_0001,
    64'h0520_0000_fbff_0000, 64'h00e0_0000_0040_0000, 64'h0020_0000_0500_0000,
    64'h0020_0000_8000_0000, 64'h8000_0000_0040_0000};
  logic [31:0] sq_tab [6] = '{32'h8000_0000, 32'h7000_0000, 32'hf600_0000,
    32'h0700_0000, 32'h0540_0000, 32'h04f0_0000};
  logic [31:0] sq_res [6] = '{32'h8000_0000, 32'h7000_0000, 32'hfb00_0000,
    32'h0300_0000, 32'hf75a_8279, 32'hf8f0_0000};

  fmds_unit dut
  (
    .CLK(clk), .RSTN(rstn), .START(start), .OP(op), .SIGNIF(signif), .MOD(mod_bits),
    .A(a), .B(b), .BUSY(busy), .DONE(done), .UPPER(upper), .LOWER(lower),
    .FLAG45(flag45), .WIDE(wide), .CTRL_VEC(ctrl_vec), .OFFSET_SEL(offset_sel),
    .BCAST(bcast), .SIGN_IDX(sign_idx)
  );
  fmds_pipe_model pm
  (
    .clk(clk), .busy(busy), .done(done), .start(start), .op(op), .signif(signif),
    .mod_bits(mod_bits), .a(a), .b(b)
  );

  // ------------------------------------------------------------
  // Clock, timeout and reporting
  // ------------------------------------------------------------
  // Toggles the clock every half period of 20 ns.
  always #20 clk = ~clk;

  // Cuts a hung run short.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      conclude();
    end
  end

  task automatic chk_word(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // ------------------------------------------------------------
  // Expected results
  // ------------------------------------------------------------
  // Forces out-of-range exponents to indefinite or machine zero.
  function automatic logic [31:0] pack_res(input int e, input logic [23:0] c);
    if (e > 111)
      return 32'h7000_0000;
    if (e < -112)
      return 32'h8000_0000;
    return {e[7:0], c};
  endfunction : pack_res

  function automatic logic [31:0] mul_exp(input logic [31:0] p1, input logic [31:0] p2,
                                          input logic hi);
    int e;
    logic [23:0] ca, cb;
    logic [46:0] p;
    if (p1[31:28] == INDEF_TAG || p2[31:28] == INDEF_TAG)
      return 32'h7000_0000;
    if (p1[31:28] == ZERO_TAG || p2[31:28] == ZERO_TAG)
      return 32'h8000_0000;
    ca = p1[23:0];
    cb = p2[23:0];
    e = int'($signed(p1[31:24])) + int'($signed(p2[31:24]));
    e = e + int'(ca == 24'h80_0000) + int'(cb == 24'h80_0000);
    ca = (ca == 24'h80_0000) ? 24'h40_0000 : (ca[23] ? -ca : ca);
    cb = (cb == 24'h80_0000) ? 24'h40_0000 : (cb[23] ? -cb : cb);
    p = 47'(ca) * 47'(cb);
    if (p1[23] ^ p2[23])
      p = -p;
    return hi ? pack_res(e + 23, p[46:23]) : pack_res(e, {1'b0, p[22:0]});
  endfunction : mul_exp

  function automatic logic [31:0] div_exp(input logic [31:0] p1, input logic [31:0] p2);
    int nc;
    logic [23:0] da, db;
    logic [45:0] q;
    if (p1[31:28] == INDEF_TAG || p2[31:28] == INDEF_TAG || p2[31:28] == ZERO_TAG ||
        p2[23:0] == 24'h00_0000)
      return 32'h7000_0000;
    if (p1[31:28] == ZERO_TAG)
      return 32'h8000_0000;
    da = p1[23] ? -p1[23:0] : p1[23:0];
    db = p2[23] ? -p2[23:0] : p2[23:0];
    nc = 0;
    // Shifts the divisor up beside the sign and counts the places.
    while (db[22] == 1'b0)
    begin
      db = db << 1;
      nc++;
    end
    q = {da, 22'h00_0000} / db;
    if (p1[23] ^ p2[23])
      q = -q;
    return pack_res($signed(p1[31:24]) - $signed(p2[31:24]) + nc - 22, q[23:0]);
  endfunction : div_exp

  // Draws a short operand with an exponent in -40..40 and a masked magnitude.
  function automatic logic [31:0] rnd_word(input logic [22:0] mask);
    int e;
    logic [23:0] c;
    e = $random(seed) % 41;
    c = {1'b0, 23'($random(seed)) & mask};
    if ($random(seed) & 1)
      c = -c;
    return {e[7:0], c};
  endfunction : rnd_word

  // ------------------------------------------------------------
  // Operations and comparisons
  // ------------------------------------------------------------
  task automatic do_op(input logic [1:0] o, input logic s, input logic poke);
    logic [7:0] m;
    m = 8'($random(seed)) & {7'h7f, !o[1]};
    pm.issue(o, s, m, {32'h0, x}, {32'h0, y}, poke);
    chk_bit("done", 1'b1, done);
    chk_word("decode", {56'h0, m}, {56'h0, sign_idx, bcast, offset_sel, ctrl_vec, wide});
  endtask : do_op

  task automatic chk_mul();
    chk_word("upper", {32'h0, mul_exp(x, y, 1'b1)}, upper);
    chk_word("lower", {32'h0, mul_exp(x, y, 1'b0)}, lower);
  endtask : chk_mul

  task automatic chk_sqrt();
    chk_bit("flag45", x[23] && x[31:28] != INDEF_TAG && x[31:28] != ZERO_TAG, flag45);
    if (x[31:28] == INDEF_TAG || x[31:28] == ZERO_TAG)
      chk_word("root", {32'h0, x[31:28], 28'h0}, upper);
    else if (x[23:0] == 24'h00_0000)
      chk_word("root", {32'h0, x[31], x[31:25], 24'h0}, upper);
  endtask : chk_sqrt

  // Resets, runs the corner tables, then random traffic.
  initial
  begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    foreach (mul_tab[i])
    begin
      {x, y} = mul_tab[i];
      do_op(OP_MUL, 1'b0, 1'b0);
      chk_mul();
    end
    {x, y} = 64'h0040_0000_0040_0000;
    do_op(OP_MUL, 1'b1, 1'b0);
    chk_word("sig upper", 64'h0000_0000_1640_0000, upper);
    chk_word("sig lower", 64'h0000_0000_ff00_0000, lower);
    foreach (div_tab[i])
    begin
      {x, y} = div_tab[i];
      do_op(OP_DIV, 1'b0, i == 0);
      chk_word("quotient", {32'h0, div_exp(x, y)}, upper);
    end
    foreach (sq_tab[i])
    begin
      x = sq_tab[i];
      do_op((i % 2) ? 2'h3 : OP_SQRT, 1'b0, 1'b0);
      chk_sqrt();
      chk_word("root table", {32'h0, sq_res[i]}, upper);
    end
    pm.issue(OP_SQRT, 1'b0, 8'h01, 64'h0004_4000_0000_0000, 64'h0000_0000_0000_0000, 1'b0);
    chk_bit("long width", 1'b1, wide);
    chk_word("long root", 64'hffeb_4000_0000_0000, upper);
    repeat (120)
    begin
      k = $random(seed) & 3;
      x = rnd_word((k == 0) ? 23'h3f_ffff : 23'h7f_ffff);
      y = rnd_word(23'h7f_ffff) | 32'h1;
      do_op((k == 0) ? OP_DIV : ((k == 1) ? OP_SQRT : OP_MUL), 1'b0, 1'b0);
      if (k == 0)
        chk_word("quotient", {32'h0, div_exp(x, y)}, upper);
      else if (k == 1)
        chk_sqrt();
      else
        chk_mul();
    end
    conclude();
  end
endmodule : tb
